// *** hw/das_pkg.sv ***
// Shared constants, state codes and helpers of the auto-sleep sequencer.
// Assumes a single 100 MHz clock; every pin input is synchronous to it.
package das_pkg;
	// Clock rate, word width and buffer depth
	localparam int CLK_MHZ = 100;
	localparam int DATA_W = 14;
	localparam int BUF_DEPTH = 2;
	// Times as printed, and the cycle counts they give
	localparam real T_CONV_US = 5.2;
	localparam real T_WAKE_EXT_US = 4.8;
	localparam real T_WAKE_INT_MS = 5.0;
	localparam int CONV_CYC = int'(T_CONV_US * CLK_MHZ);
	localparam int WAKE_EXT_CYC = int'(T_WAKE_EXT_US * CLK_MHZ);
	localparam int WAKE_INT_CYC = int'(T_WAKE_INT_MS * 1000.0 * CLK_MHZ);
	// Reset level of the sampled active-low strobes
	localparam logic RST_PIN_N = 1'b1;

	// Sequencer states, one-hot
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_CONV = 5'h02,
		ST_STORE = 5'h04,
		ST_SLEEP = 5'h08,
		ST_WAKE = 5'h10
	} das_state_e;

	// Edge helpers on a sampled pin and its previous value
	function automatic logic das_fell(input logic prev, input logic cur);
		return prev & ~cur;
	endfunction

	function automatic logic das_rose(input logic prev, input logic cur);
		return ~prev & cur;
	endfunction
endpackage

// *** hw/das_fifo_if.sv ***
// Valid/ready channel between the sequencer and its result buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface das_fifo_if #(parameter int W = 14) ();
	logic in_valid;
	logic in_ready;
	logic [W-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [W-1:0] out_data;
	logic flush;

	// Buffer side
	modport store (
		input in_valid, in_data, out_ready, flush,
		output in_ready, out_valid, out_data
	);
	// Sequencer side
	modport ctrl (
		output in_valid, in_data, out_ready, flush,
		input in_ready, out_valid, out_data
	);
endinterface
`default_nettype wire

// *** hw/das_pair_buf.sv ***
// Small result buffer with valid/ready on both sides.
// Assumes the filling side waits on in_ready and the drain pops on ready.
`timescale 1ns/100ps
`default_nettype none
module das_pair_buf #(
	parameter int W = das_pkg::DATA_W,
	parameter int DEPTH = das_pkg::BUF_DEPTH
) (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	das_fifo_if.store fifo
);
	import das_pkg::*;

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} das_buf_s;

	das_buf_s q;
	das_buf_s d;
	logic push;
	logic pop;

	////////////////////////////////////////////////////////////////////////
	// Honest flags straight from the fill count
	assign fifo.in_ready = (q.cnt != (AW+1)'(DEPTH));
	assign fifo.out_valid = (q.cnt != '0);
	assign fifo.out_data = q.mem[q.rp];
	assign push = fifo.in_valid & fifo.in_ready;
	assign pop = fifo.out_valid & fifo.out_ready;

	// Next state; flush drops stale words but a push still lands
	always_comb begin
		d = q;
		if (fifo.flush) begin
			d.rp = q.wp;
			d.cnt = '0;
		end else if (pop) begin
			d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
		end
		if (push) begin
			d.mem[q.wp] = fifo.in_data;
			d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
		end
		if (!fifo.flush) begin
			unique case ({push, pop})
				2'b10: d.cnt = q.cnt + 1'b1;
				2'b01: d.cnt = q.cnt - 1'b1;
				default: d.cnt = q.cnt;
			endcase
		end else if (push) begin
			d.cnt = (AW+1)'(1);
		end
	end

	// Registers; the clock enable freezes everything
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			q <= '0;
		end else if (i_ce) begin
			q <= d;
		end
	end
endmodule
`default_nettype wire

// *** hw/das_sequencer.sv ***
// Wake, hold, convert and sleep sequencing plus the parallel read port.
// Assumes all pins are synchronous to i_core_clk; inputs stand in for the
// digitised channel values that the converters would produce.
`timescale 1ns/100ps
`default_nettype none
module das_sequencer #(
	parameter int DW = das_pkg::DATA_W,
	parameter int CONV_CYC = das_pkg::CONV_CYC,
	parameter int WAKE_EXT_CYC = das_pkg::WAKE_EXT_CYC,
	parameter int WAKE_INT_CYC = das_pkg::WAKE_INT_CYC
) (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	input wire logic i_conversion_start_n,
	input wire logic i_input_pair_select,
	input wire logic i_ext_ref,
	input wire logic i_cs_n,
	input wire logic i_rd_n,
	input wire logic [DW-1:0] i_pair_a_first_input,
	input wire logic [DW-1:0] i_pair_a_second_input,
	input wire logic [DW-1:0] i_pair_b_first_input,
	input wire logic [DW-1:0] i_pair_b_second_input,
	output logic o_busy,
	output logic o_power_down,
	output logic o_hold,
	output logic [DW-1:0] o_data,
	output logic o_data_oe
);
	import das_pkg::*;

	// Counter sized for the longest wait, whichever count that turns out
	// to be; short test counts must not truncate the conversion count
	localparam int WAKE_MAX = (WAKE_INT_CYC > WAKE_EXT_CYC) ? WAKE_INT_CYC
		: WAKE_EXT_CYC;
	localparam int LONGEST = (WAKE_MAX > CONV_CYC) ? WAKE_MAX : CONV_CYC;
	localparam int CW = $clog2(LONGEST + 1);

	typedef struct packed {
		das_state_e st;
		logic [CW-1:0] cnt;
		logic conv_n;
		logic rd_n;
		logic int_ref;
		logic pair_b;
		logic second;
		logic [DW-1:0] first_hold;
		logic [DW-1:0] second_hold;
		logic busy;
		logic power_down;
		logic hold;
		logic [DW-1:0] data;
		logic data_oe;
	} das_seq_s;

	localparam das_seq_s SEQ_RST = '{
		st: ST_IDLE,
		conv_n: RST_PIN_N,
		rd_n: RST_PIN_N,
		default: '0
	};

	das_seq_s q;
	das_seq_s d;
	logic conv_fell;
	logic conv_rose;
	logic rd_fell;
	logic hold_now;
	logic push;
	logic [CW-1:0] wake_last;

	das_fifo_if #(.W(DW)) fifo ();

	// Track-and-hold mux: pair B when select is high
	function automatic logic [DW-1:0] das_pick(
		input logic sel_b,
		input logic [DW-1:0] a,
		input logic [DW-1:0] b
	);
		return sel_b ? b : a;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin edges, taken against last cycle's samples
	assign conv_fell = das_fell(q.conv_n, i_conversion_start_n);
	assign conv_rose = das_rose(q.conv_n, i_conversion_start_n);
	// A strobe edge only counts while the part is selected
	assign rd_fell = das_fell(q.rd_n, i_rd_n) & ~i_cs_n;
	// Wake length follows the reference chosen at the wake edge
	assign wake_last = q.int_ref ? CW'(WAKE_INT_CYC - 1)
		: CW'(WAKE_EXT_CYC - 1);

	////////////////////////////////////////////////////////////////////////
	// Buffer hookup: results go in word by word, reads pop them
	assign fifo.in_valid = push;
	assign fifo.in_data = q.second ? q.second_hold : q.first_hold;
	// A new hold discards unread words; a read with the buffer empty shows the last word read again
	assign fifo.flush = hold_now;
	assign fifo.out_ready = rd_fell;

	das_pair_buf #(
		.W(DW),
		.DEPTH(BUF_DEPTH)
	) u_buf (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_ce(i_ce),
		.fifo(fifo)
	);

	////////////////////////////////////////////////////////////////////////
	// Sequencer next state
	always_comb begin
		d = q;
		hold_now = 1'b0;
		push = 1'b0;
		d.conv_n = i_conversion_start_n;
		d.rd_n = i_rd_n;
		unique case (q.st)
			ST_IDLE: begin
				// Awake and idle: hold on the falling edge
				if (conv_fell) begin
					hold_now = 1'b1;
				end
			end
			ST_CONV: begin
				d.cnt = q.cnt + 1'b1;
				if (q.cnt == CW'(CONV_CYC - 1)) begin
					d.st = ST_STORE;
					d.second = 1'b0;
				end
			end
			ST_STORE: begin
				// Waits here while the buffer cannot take a word
				push = 1'b1;
				if (fifo.in_ready) begin
					if (q.second) begin
						d.busy = 1'b0;
						d.hold = 1'b0;
						d.second = 1'b0;
						// Start still low at the end picks auto-sleep
						if (!i_conversion_start_n) begin
							d.st = ST_SLEEP;
							d.power_down = 1'b1;
						end else begin
							d.st = ST_IDLE;
						end
					end else begin
						d.second = 1'b1;
					end
				end
			end
			ST_SLEEP: begin
				// Only a rising edge wakes the part
				if (conv_rose) begin
					d.st = ST_WAKE;
					d.power_down = 1'b0;
					d.cnt = '0;
					d.int_ref = ~i_ext_ref;
				end
			end
			ST_WAKE: begin
				d.cnt = q.cnt + 1'b1;
				// Busy rises at once even if hold must wait for wake-up
				if (conv_fell) begin
					d.busy = 1'b1;
				end
				if (q.cnt == wake_last) begin
					if (!i_conversion_start_n) begin
						hold_now = 1'b1;
					end else begin
						// Hold then waits for the next falling edge
						d.st = ST_IDLE;
						// A fall that rose again before wake end leaves no
						// conversion behind, so busy must not stand
						d.busy = 1'b0;
					end
				end
			end
		endcase
		// Hold point: both channels sampled together, timing restarts
		if (hold_now) begin
			d.st = ST_CONV;
			d.cnt = '0;
			d.busy = 1'b1;
			d.hold = 1'b1;
			d.second = 1'b0;
			d.pair_b = i_input_pair_select;
			d.first_hold = das_pick(i_input_pair_select,
				i_pair_a_first_input, i_pair_b_first_input);
			d.second_hold = das_pick(i_input_pair_select,
				i_pair_a_second_input, i_pair_b_second_input);
		end
		// Read port works in every state, sleep included
		if (rd_fell && fifo.out_valid) begin
			d.data = fifo.out_data;
		end
		d.data_oe = ~i_cs_n & ~i_rd_n;
	end

	////////////////////////////////////////////////////////////////////////
	// State register; clock enable low freezes the whole block
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			q <= SEQ_RST;
		end else if (i_ce) begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs come straight from the state register
	assign o_busy = q.busy;
	assign o_power_down = q.power_down;
	assign o_hold = q.hold;
	assign o_data = q.data;
	assign o_data_oe = q.data_oe;
endmodule
`default_nettype wire

// *** sim/das_seq_asserts.sv ***
// Port assertions for the auto-sleep sequencer.
// Checks pause while i_ce is low; pins move away from the rising edge.
`timescale 1ns/100ps
`default_nettype none
module das_seq_asserts #(
	parameter int CONV_CYC = 20,
	parameter int WAKE_EXT_CYC = 12,
	parameter int WAKE_INT_CYC = 30
) (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	input wire logic i_conversion_start_n,
	input wire logic i_ext_ref,
	input wire logic i_cs_n,
	input wire logic i_rd_n,
	input wire logic o_busy,
	input wire logic o_power_down,
	input wire logic o_hold,
	input wire logic [13:0] o_data,
	input wire logic o_data_oe
);
	localparam int T_DONE = CONV_CYC + 2;
	localparam int E_LO = WAKE_EXT_CYC - 3;
	localparam int E_HI = WAKE_EXT_CYC + 3;
	localparam int N_LO = WAKE_INT_CYC - 3;
	localparam int N_HI = WAKE_INT_CYC + 3;
	default clocking cb @(posedge i_core_clk);
	endclocking
	// A frozen block keeps its state, so timing checks stand aside then
	default disable iff (i_srst || !i_ce);
	////////////////////////////////////////
	// Wake from sleep with the next start right behind it
	sequence s_wake(e);
		o_power_down && $rose(i_conversion_start_n) && i_ext_ref == e
			##1 $fell(i_conversion_start_n);
	endsequence
	// Busy and hold drop together once results are stored
	sequence s_done;
		$fell(o_busy) && $fell(o_hold);
	endsequence
	busy_rise_a:
		assert property ($fell(i_conversion_start_n) && !o_busy &&
			!o_power_down |=> o_busy) else $error("busy missed start");
	conv_len_a:
		assert property ($rose(o_hold) |-> ##T_DONE s_done)
			else $error("conversion length wrong");
	sleep_in_a:
		assert property ($fell(o_busy) && !i_conversion_start_n &&
			!$past(i_conversion_start_n) |-> o_power_down)
			else $error("no sleep after busy fell");
	stay_awake_a:
		assert property ($fell(o_busy) && i_conversion_start_n &&
			$past(i_conversion_start_n) |-> !o_power_down)
			else $error("slept with start high");
	wake_up_a:
		assert property (o_power_down && $rose(i_conversion_start_n)
			|=> !o_power_down) else $error("rise did not wake");
	wake_ext_a:
		assert property (s_wake(1'b1) |-> ##[E_LO:E_HI] $rose(o_hold))
			else $error("hold late after external wake");
	wake_int_a:
		assert property (s_wake(1'b0) |-> ##[N_LO:N_HI] $rose(o_hold))
			else $error("hold late after internal wake");
	oe_track_a:
		assert property (o_data_oe == $past(!i_cs_n && !i_rd_n))
			else $error("bus drive without select and strobe");
	data_hold_a:
		assert property (!($fell(i_rd_n) && !i_cs_n) |=> $stable(o_data))
			else $error("data changed without a read");
	hold_busy_a:
		assert property (o_hold |-> o_busy) else $error("hold without busy");
endmodule
bind das_sequencer das_seq_asserts #(.CONV_CYC(CONV_CYC),
	.WAKE_EXT_CYC(WAKE_EXT_CYC), .WAKE_INT_CYC(WAKE_INT_CYC))
	das_seq_asserts_i (.i_core_clk(i_core_clk), .i_srst(i_srst),
	.i_ce(i_ce), .i_conversion_start_n(i_conversion_start_n),
	.i_ext_ref(i_ext_ref),
	.i_cs_n(i_cs_n), .i_rd_n(i_rd_n), .o_busy(o_busy),
	.o_power_down(o_power_down), .o_hold(o_hold), .o_data(o_data),
	.o_data_oe(o_data_oe));
`default_nettype wire

// *** sim/das_host_model.sv ***
// Host side: drives start, select and strobe, samples the data bus.
// Assumes it is called on falling clock edges by the bench.
`timescale 1ns/100ps
`default_nettype none
module das_host_model (
	input wire logic i_core_clk,
	input wire logic [13:0] i_bus,
	output logic o_start_n,
	output logic o_cs_n,
	output logic o_rd_n
);
	int quiet = 100;
	initial begin
		o_start_n = 1'b1;
		o_cs_n = 1'b1;
		o_rd_n = 1'b1;
	end
	// Cycles since the last read ended
	always @(posedge i_core_clk) quiet <= quiet + 1;
	////////////////////////////////////////
	// Start pin; a fall first waits out the settling gap after reads
	task automatic drive_start(input logic v);
		while (!v && quiet < 40)
			@(negedge i_core_clk);
		o_start_n = v;
	endtask
	// One strobe; the word is taken while the bus is driven
	task automatic strobe(output logic [13:0] w);
		o_rd_n = 1'b0;
		repeat (2) @(negedge i_core_clk);
		w = i_bus;
		o_rd_n = 1'b1;
		@(negedge i_core_clk);
	endtask
	// Two strobes inside one select pulse, same place both times
	task automatic read_pair(input logic en, output logic [13:0] w1, w2);
		o_cs_n = !en;
		@(negedge i_core_clk);
		strobe(w1);
		strobe(w2);
		o_cs_n = 1'b1;
		quiet = 0;
		@(negedge i_core_clk);
	endtask
endmodule
`default_nettype wire

// *** sim/tb_das_sequencer.sv ***
// Self-checking bench for the auto-sleep sequencer.
// Assumes short wake and conversion counts set through parameters.
`timescale 1ns/100ps
`default_nettype none
module tb_das_sequencer;
	import das_pkg::*;
	localparam int CONV = 20;
	localparam int WEXT = 12;
	localparam int WINT = 30;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic sel = 1'b0;
	logic ext = 1'b1;
	logic ce = 1'b1;
	logic [13:0] a1, a2, b1, b2, data, w1, w2;
	logic busy, pd, hold, oe, start_n, cs_n, rd_n;
	wire logic [13:0] bus;
	int bad_count = 0;
	int n_checks = 0;
	int cyc = 0;
	int n;
	// Clock; a released bus shows the inverse word, never a stale one
	always #5 clk = ~clk;
	assign bus = oe ? data : ~data;
	das_sequencer #(.CONV_CYC(CONV), .WAKE_EXT_CYC(WEXT),
		.WAKE_INT_CYC(WINT)) das_sequencer_i (.i_core_clk(clk),
		.i_srst(srst), .i_ce(ce), .i_conversion_start_n(start_n),
		.i_input_pair_select(sel), .i_ext_ref(ext), .i_cs_n(cs_n),
		.i_rd_n(rd_n), .i_pair_a_first_input(a1),
		.i_pair_a_second_input(a2), .i_pair_b_first_input(b1),
		.i_pair_b_second_input(b2), .o_busy(busy), .o_power_down(pd),
		.o_hold(hold), .o_data(data), .o_data_oe(oe));
	das_host_model das_host_model_i (.i_core_clk(clk), .i_bus(bus),
		.o_start_n(start_n), .o_cs_n(cs_n), .o_rd_n(rd_n));
	////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("checks=%0d mismatches=%0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic set_in(input logic [13:0] v);
		a1 = v;
		a2 = v + 14'h1;
		b1 = v + 14'h2;
		b2 = v + 14'h3;
	endtask
	// Start falls; n is cycles until busy drops, used as the interrupt
	task automatic convert(input logic stay_low);
		int t0;
		@(negedge clk);
		das_host_model_i.drive_start(1'b0);
		t0 = cyc;
		if (!stay_low) begin
			@(negedge clk);
			das_host_model_i.drive_start(1'b1);
		end
		do @(negedge clk);
		while (busy !== 1'b0 && cyc - t0 < 2000);
		n = cyc - t0;
	endtask
	task automatic t_awake;
		set_in(14'h0101);
		sel = 1'b0;
		convert(1'b0);
		chk(n, CONV + 3);
		chk(pd, 1'b0);
		das_host_model_i.read_pair(1'b0, w1, w2); // No select
		das_host_model_i.read_pair(1'b1, w1, w2);
		chk({w1, w2}, {14'h0101, 14'h0102});
	endtask
	task automatic t_sleep;
		set_in(14'h0a20);
		sel = 1'b1;
		convert(1'b1);
		chk({n[7:0], pd}, {8'(CONV + 3), 1'b1});
		das_host_model_i.read_pair(1'b1, w1, w2);
		chk({w1, w2, pd}, {14'h0a22, 14'h0a23, 1'b1});
	endtask
	// Start stays high past the wake time; hold waits for the fall
	task automatic t_late;
		@(negedge clk);
		das_host_model_i.drive_start(1'b1);
		repeat (WEXT + 10) @(negedge clk);
		chk({pd, busy, hold}, 3'h0);
		set_in(14'h1230);
		sel = 1'b0;
		convert(1'b1);
		chk(n, CONV + 3);
		das_host_model_i.read_pair(1'b1, w1, w2);
		chk({w1, w2}, {14'h1230, 14'h1231});
	endtask
	task automatic t_wake(input logic e, input int w, input logic [13:0] v);
		repeat (40) @(negedge clk);
		ext = e;
		sel = e;
		set_in(v);
		das_host_model_i.drive_start(1'b1);
		convert(1'b1);
		chk(n >= w + CONV && n <= w + CONV + 6, 1'b1);
		das_host_model_i.read_pair(1'b1, w1, w2);
		chk(w1, e ? v + 14'h2 : v);
		chk(w2, e ? v + 14'h3 : v + 14'h1);
	endtask
	// Clock enable low freezes the sleeping part through a wake edge;
	// the edge is only acted on once the enable returns
	task automatic t_freeze;
		@(negedge clk);
		ce = 1'b0;
		das_host_model_i.drive_start(1'b1);
		repeat (5) @(negedge clk);
		chk({pd, busy, hold}, 3'h4);
		ce = 1'b1;
		repeat (2) @(negedge clk);
		chk(pd, 1'b0);
		repeat (WINT + 4) @(negedge clk);
		chk({pd, busy, hold}, 3'h0);
	endtask
	////////////////////////////////////////
	// Main sequence after 20 reset cycles
	initial begin
		set_in(14'h0);
		repeat (20) @(negedge clk);
		srst = 1'b0;
		t_awake;
		t_sleep;
		t_late;
		t_wake(1'b1, WEXT, 14'h0150);
		t_wake(1'b0, WINT, 14'h0260);
		t_freeze;
		results;
	end
	// Hang guard, well above the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			bad_count++;
			results;
		end
	end
endmodule
`default_nettype wire
